/* bench/qrr_checker.sv */
// port checker for the query request responder
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "qrr_consts.svh"
// ============================================================
// checker
module qrr_checker #(
    parameter int SENSOR_HALF = 25
)(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [`QRR_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_busy,
    input wire logic [6:0] i_lock,
    input wire logic [6:0] i_setting,
    input wire logic i_sensor_data,
    input wire logic o_sensor_clk,
    input wire logic o_sensor_sel_n,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_data,
    input wire logic o_mem_req,
    input wire logic o_mem_user,
    input wire logic [`QRR_STORE_ADDR_W-1:0] o_mem_addr
);
    logic sclk_q;
    logic [7:0] hi_q;
    logic [13:0] pins_d1_q, pins_d2_q, stat_q;
    logic [4:0] rise_q;
    logic [4:0] rise_d;
    // rises counted one cycle late; the frame ends well after the last rise
    always_comb
    begin
        rise_d = o_sensor_sel_n ? 5'h0 : rise_q + 5'(o_sensor_clk && !sclk_q);
    end
    always_ff @(posedge i_mclk)
    begin
        sclk_q <= i_rst ? 1'b0 : o_sensor_clk;
        rise_q <= i_rst ? 5'h0 : rise_d;
        hi_q <= (i_rst || !o_sensor_clk) ? 8'h00 : hi_q + 8'h01;
        // pins as the design's two-flop synchroniser shows them at the write
        pins_d1_q <= {i_lock, i_setting};
        pins_d2_q <= pins_d1_q;
        if (i_wr && i_addr == `QRR_OFF_STATUS_REQ && i_wdata == `QRR_ARG_STATUS && !o_busy)
            stat_q <= pins_d2_q;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_temp_start;
        i_wr && i_addr == `QRR_OFF_TEMP_REQ && i_wdata == `QRR_ARG_TEMP && !o_busy |=> o_busy && !o_sensor_sel_n;
    endproperty
    a_temp_start: assert property (p_temp_start)
        else $error("temperature request did not start a frame");
    property p_cal_start;
        i_wr && i_addr == `QRR_OFF_CAL_REQ && !o_busy
            |=> o_mem_req && !o_mem_user && o_mem_addr == $past(i_wdata[13:0]);
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration fetch wrong");
    property p_user_start;
        i_wr && i_addr == `QRR_OFF_USER_REQ && !o_busy
            |=> o_mem_req && o_mem_user && o_mem_addr == $past(i_wdata[13:0]);
    endproperty
    a_user_start: assert property (p_user_start)
        else $error("user fetch wrong");
    property p_req_hold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_user);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("store request dropped before ack");
    property p_ack_done;
        o_mem_req && i_mem_ack |=> !o_mem_req && o_busy ##1 !o_busy;
    endproperty
    a_ack_done: assert property (p_ack_done)
        else $error("store completion timing wrong");
    property p_sclk_idle;
        o_sensor_sel_n |-> !o_sensor_clk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("sensor clock runs outside a frame");
    property p_frame_len;
        $rose(o_sensor_sel_n) |-> rise_q == 5'h10;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("sensor frame length wrong");
    property p_status;
        i_wr && i_addr == `QRR_OFF_STATUS_REQ && i_wdata == `QRR_ARG_STATUS && !o_busy
            ##[1:8] i_rd && i_addr == `QRR_OFF_RESPONSE
            |=> o_rdata == {16'h0, stat_q[13:7], 1'b0, stat_q[6:0], 1'b0};
    endproperty
    a_status: assert property (p_status)
        else $error("status word wrong");
    property p_sclk_half;
        $fell(o_sensor_clk) |-> hi_q == 8'(SENSOR_HALF);
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("sensor clock high phase length wrong");
endmodule
bind query_request_responder qrr_checker #(.SENSOR_HALF(SENSOR_HALF)) i_qrr_checker (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_busy(o_busy), .i_lock(i_lock), .i_setting(i_setting),
    .i_sensor_data(i_sensor_data), .o_sensor_clk(o_sensor_clk), .o_sensor_sel_n(o_sensor_sel_n),
    .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_mem_req(o_mem_req),
    .o_mem_user(o_mem_user), .o_mem_addr(o_mem_addr));
`default_nettype wire

/* bench/qrr_far_side.sv */
// model of the temperature sensor and the two stores
// assumes the responder's sensor and store pins on the same clock
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// sensor and store model
module qrr_far_side (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic [13:0] i_temp,
    input wire logic i_sensor_clk,
    input wire logic i_sensor_sel_n,
    input wire logic i_mem_req,
    input wire logic i_mem_user,
    input wire logic [13:0] i_mem_addr,
    output logic o_sensor_data,
    output logic o_mem_ack,
    output logic [7:0] o_mem_data
);
    logic [15:0] sreg_q;
    logic sclk_q;
    logic idle_q;
    logic served_q;
    logic [2:0] wait_q;
    function automatic logic [7:0] store_byte(input logic user, input logic [13:0] a);
        return a[7:0] ^ {2'h0, a[13:8]} ^ (user ? 8'ha5 : 8'h3c);
    endfunction
    // released line toggles so a stale bit never passes for data
    assign o_sensor_data = i_sensor_sel_n ? idle_q : sreg_q[15];
    always_ff @(posedge i_mclk)
    begin
        sclk_q <= i_sensor_clk;
        idle_q <= i_rst ? 1'b0 : ~idle_q;
        if (i_sensor_sel_n)
            sreg_q <= {2'h2, i_temp};
        else if (sclk_q && !i_sensor_clk)
            sreg_q <= {sreg_q[14:0], 1'b0};
        o_mem_ack <= 1'b0;
        o_mem_data <= i_rst ? 8'h0 : ~o_mem_data;
        if (i_rst || !i_mem_req)
        begin
            served_q <= 1'b0;
            wait_q <= 3'h0;
        end
        else if (!served_q)
        begin
            wait_q <= wait_q + 3'h1;
            if (wait_q >= (i_slow ? 3'h5 : 3'h0))
            begin
                o_mem_ack <= 1'b1;
                o_mem_data <= store_byte(i_mem_user, i_mem_addr);
                served_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/tb_query_request_responder.sv */
// testbench for the query request responder
// assumes the far-side model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
`include "qrr_consts.svh"
// ============================================================
// bench
module tb_query_request_responder;
    logic mclk, rst, wr_stb, rd_stb, slow, sdata, sclk, sel_n, ack, busy, req, user;
    logic [7:0] addr, mdata;
    logic [31:0] wdata, rdata, r, w;
    logic [6:0] lock, setting;
    logic [13:0] temp, maddr;
    int deg;
    int n_mismatch = 0;
    int cmp_count = 0;
    query_request_responder #(.SENSOR_HALF(4)) i_query_request_responder (
        .i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb),
        .o_rdata(rdata), .o_busy(busy), .i_lock(lock), .i_setting(setting), .i_sensor_data(sdata),
        .o_sensor_clk(sclk), .o_sensor_sel_n(sel_n), .i_mem_ack(ack), .i_mem_data(mdata),
        .o_mem_req(req), .o_mem_user(user), .o_mem_addr(maddr));
    qrr_far_side i_qrr_far_side (
        .i_mclk(mclk), .i_rst(rst), .i_slow(slow), .i_temp(temp), .i_sensor_clk(sclk),
        .i_sensor_sel_n(sel_n), .i_mem_req(req), .i_mem_user(user), .i_mem_addr(maddr),
        .o_sensor_data(sdata), .o_mem_ack(ack), .o_mem_data(mdata));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ============================================================
    // tasks
    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    // poll flags until idle and done, then take the response
    task automatic fetch(output logic [31:0] d);
        logic [31:0] f;
        f = 32'h0;
        repeat (100)
        begin
            bus_rd(`QRR_OFF_FLAGS, f);
            if (f[1:0] === 2'b10)
                break;
        end
        chk("done", f & 32'h3, 32'h2);
        bus_rd(`QRR_OFF_RESPONSE, d);
    endtask
    // ============================================================
    // sequence
    initial
    begin
        rst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h0; wdata = 32'h0;
        slow = 1'b0; temp = 14'h0; lock = 7'h0; setting = 7'h0; w = 32'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            lock <= p ? 7'h13 : 7'h6d;
            setting <= p ? 7'h55 : 7'h2a;
            repeat (5) @(posedge mclk);
            bus_wr(`QRR_OFF_STATUS_REQ, `QRR_ARG_STATUS);
            fetch(r);
            chk("status", r, {16'h0, lock, 1'b0, setting, 1'b0});
            chk("first_osc_lock", 32'(r[13] & r[10] & r[9]), 32'(p));
        end
        // two readings only: sensor clocking disturbs the signal path
        for (int t = 0; t < 2; t++)
        begin
            temp <= t ? 14'h3f00 : 14'h0320;
            bus_wr(`QRR_OFF_TEMP_REQ, `QRR_ARG_TEMP);
            if (t == 1)
                bus_wr(`QRR_OFF_CAL_REQ, 32'h5);
            fetch(r);
            chk("temperature", r, {18'h0, temp});
            chk("sign", r & 32'h2000, t ? 32'h2000 : 32'h0);
            deg = r[13] ? (int'(r[12:0]) - 32'sh0000_2000) / 32'sh0000_0020 : int'(r[12:0]) / 32'sh0000_0020;
            chk("celsius", 32'(deg), t ? 32'hffff_fff8 : 32'h0000_0019);
        end
        for (int b = 0; b < 4; b++)
        begin
            slow <= b[0];
            bus_wr(`QRR_OFF_CAL_REQ, 32'h3ffe + b);
            fetch(r);
            chk("cal_high", r & 32'hffffff00, 32'h0);
            w = w | (r << (8 * b));
        end
        chk("cal_word", w, {i_qrr_far_side.store_byte(1'b0, 14'h1), i_qrr_far_side.store_byte(1'b0, 14'h0),
            i_qrr_far_side.store_byte(1'b0, 14'h3fff), i_qrr_far_side.store_byte(1'b0, 14'h3ffe)});
        for (int u = 0; u < 2; u++)
        begin
            bus_wr(`QRR_OFF_USER_REQ, u ? 32'hc00a : 32'h0007);
            fetch(r);
            chk("user", r, {24'h0, i_qrr_far_side.store_byte(1'b1, u ? 14'h000a : 14'h0007)});
        end
        bus_rd(8'h30, r);
        chk("unmapped", r, 32'h0);
        bus_wr(`QRR_OFF_TEMP_REQ, 32'h1);
        bus_rd(`QRR_OFF_FLAGS, r);
        chk("badarg", r & 32'h7fd, 32'hcc);
        bus_rd(`QRR_OFF_TEMP_REQ, r);
        chk("last_arg", r, 32'h1);
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire

/* verilog/qrr_consts.svh */
// constants for the query request responder: register offsets, argument
// codes, field positions and timing figures; included by bare name
`ifndef QRR_CONSTS_SVH
`define QRR_CONSTS_SVH

`define QRR_ADDR_W 8
`define QRR_OFF_STATUS_REQ 8'h18
`define QRR_OFF_TEMP_REQ 8'h19
`define QRR_OFF_CAL_REQ 8'h20
`define QRR_OFF_USER_REQ 8'h22
`define QRR_OFF_RESPONSE 8'h40
`define QRR_OFF_FLAGS 8'h44

`define QRR_ARG_STATUS 32'h0000_0001
`define QRR_ARG_TEMP 32'h0000_0000

`define QRR_STORE_ADDR_W 14
`define QRR_TEMP_W 14
`define QRR_SENSOR_FRAME 5'h10

`define QRR_FLAG_BUSY 0
`define QRR_FLAG_DONE 1
`define QRR_FLAG_BADARG 2

`define QRR_CLK_NS 4
`define QRR_SENSOR_SCLK_NS 200

`endif

/* verilog/qrr_pkg.sv */
// types shared by the query request responder modules
// assumes qrr_consts.svh supplies the numeric constants
package qrr_pkg;
    typedef enum logic [1:0] {REQ_IDLE, REQ_TEMP, REQ_STORE} req_state_t;
    typedef enum logic [1:0] {SEN_IDLE, SEN_LOW, SEN_HIGH} sen_state_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} store_state_t;
endpackage

/* verilog/query_request_responder.sv */
// request/response unit: status, temperature, calibration and user store bytes
// assumes a same-clock register master; lock and setting flags arrive as pins
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "qrr_consts.svh"

// Function
// [RULE1] status request with argument 0x01 returns the 16-bit status word
// [RULE2] host ANDs status bits 13, 10, 9 for first oscillator lock
// [RULE3] bits 15,14,12,11: 10 MHz, 100 MHz, second, third oscillator lock
// [RULE4] bits 7..1 setting flags in order; bits 8 and 0 reserved zero
// [RULE5] temperature request with argument 0x00 returns the temperature reading
// [RULE6] reading in bits 13..0: bit 13 sign, bits 12..0 converter code
// [RULE7] host converts code by /32, or (code-8192)/32 when negative
// [RULE8] calibration request: argument gives address, byte returned in low byte
// [RULE9] store address is 14 bits; higher addresses wrap to the bottom
// [RULE10] host assembles four bytes, lowest address least significant
// [RULE11] user store request behaves like the calibration store request
// [RULE12] temperature obtained by a serial transfer to the internal sensor
// [RULE13] host should not poll temperature often; sensor clock causes spurs
// [RULE14] response valid only after access completes; busy shown until then
module query_request_responder #(
    parameter int SENSOR_HALF = `QRR_SENSOR_SCLK_NS / (2 * `QRR_CLK_NS)
)(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [`QRR_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_busy,
    input wire logic [6:0] i_lock,
    input wire logic [6:0] i_setting,
    input wire logic i_sensor_data,
    output logic o_sensor_clk,
    output logic o_sensor_sel_n,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_data,
    output logic o_mem_req,
    output logic o_mem_user,
    output logic [`QRR_STORE_ADDR_W-1:0] o_mem_addr
);
    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [13:0] flags_meta_q, flags_q;

    always_ff @(posedge i_mclk)
    begin
        flags_meta_q <= {i_lock, i_setting};
        flags_q <= flags_meta_q;
    end

    function automatic logic [15:0] status_word(input logic [6:0] lk, input logic [6:0] st);
        // lk: 10M, 100M, first osc main, second, third, first osc pll1, pll2
        // st: ext ref, ref out, ref lock, if filter, preamp, standby, backplane
        status_word = {lk, 1'b0, st, 1'b0}; // RULE3 RULE4
    endfunction

    // ==========================================================
    // request decode and sequencing
    // ==========================================================
    qrr_pkg::req_state_t state_q, state_d;
    logic [31:0] resp_q, resp_d;
    logic [31:0] arg_q, arg_d;
    logic [7:0] last_req_q, last_req_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic badarg_q, badarg_d;
    logic temp_start, store_start, store_user;
    logic temp_done, store_done;
    logic [`QRR_TEMP_W-1:0] temp_val;
    logic [7:0] store_byte;
    logic [`QRR_STORE_ADDR_W-1:0] store_addr;

    // requests arriving while busy are dropped so a response never mixes sources
    always_comb
    begin
        state_d = state_q;
        resp_d = resp_q;
        arg_d = arg_q;
        last_req_d = last_req_q;
        busy_d = busy_q;
        done_d = done_q;
        badarg_d = badarg_q;
        temp_start = 1'b0;
        store_start = 1'b0;
        store_user = 1'b0;
        store_addr = i_wdata[`QRR_STORE_ADDR_W-1:0]; // RULE9
        case (state_q)
            qrr_pkg::REQ_IDLE:
            begin
                if (i_wr)
                begin
                    case (i_addr)
                        `QRR_OFF_STATUS_REQ:
                        begin
                            last_req_d = i_addr;
                            arg_d = i_wdata;
                            badarg_d = (i_wdata != `QRR_ARG_STATUS);
                            if (i_wdata == `QRR_ARG_STATUS)
                            begin
                                resp_d = {16'h0000, status_word(flags_q[13:7], flags_q[6:0])}; // RULE1
                                done_d = 1'b1;
                            end
                        end
                        `QRR_OFF_TEMP_REQ:
                        begin
                            last_req_d = i_addr;
                            arg_d = i_wdata;
                            badarg_d = (i_wdata != `QRR_ARG_TEMP);
                            if (i_wdata == `QRR_ARG_TEMP)
                            begin
                                temp_start = 1'b1; // RULE5
                                busy_d = 1'b1;
                                done_d = 1'b0;
                                state_d = qrr_pkg::REQ_TEMP;
                            end
                        end
                        `QRR_OFF_CAL_REQ, `QRR_OFF_USER_REQ:
                        begin
                            last_req_d = i_addr;
                            arg_d = i_wdata;
                            badarg_d = 1'b0;
                            store_start = 1'b1; // RULE8 RULE11
                            store_user = (i_addr == `QRR_OFF_USER_REQ);
                            busy_d = 1'b1;
                            done_d = 1'b0;
                            state_d = qrr_pkg::REQ_STORE;
                        end
                        default:
                        begin
                            state_d = qrr_pkg::REQ_IDLE;
                        end
                    endcase
                end
            end
            qrr_pkg::REQ_TEMP:
            begin
                if (temp_done)
                begin
                    resp_d = {18'h00000, temp_val}; // RULE6 RULE14
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = qrr_pkg::REQ_IDLE;
                end
            end
            qrr_pkg::REQ_STORE:
            begin
                if (store_done)
                begin
                    resp_d = {24'h000000, store_byte}; // RULE8 RULE14
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = qrr_pkg::REQ_IDLE;
                end
            end
            default:
            begin
                state_d = qrr_pkg::REQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_q <= qrr_pkg::REQ_IDLE;
            resp_q <= 32'h0000_0000;
            arg_q <= 32'h0000_0000;
            last_req_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            badarg_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            resp_q <= resp_d;
            arg_q <= arg_d;
            last_req_q <= last_req_d;
            busy_q <= busy_d;
            done_q <= done_d;
            badarg_q <= badarg_d;
        end
    end

    // ==========================================================
    // register read port
    // ==========================================================
    logic [31:0] rdata_q, rdata_d;

    always_comb
    begin
        rdata_d = rdata_q;
        if (i_rd)
        begin
            case (i_addr)
                `QRR_OFF_RESPONSE: rdata_d = resp_q;
                `QRR_OFF_FLAGS: rdata_d = {21'h000000, last_req_q, badarg_q, done_q, busy_q}; // RULE14
                `QRR_OFF_STATUS_REQ, `QRR_OFF_TEMP_REQ, `QRR_OFF_CAL_REQ, `QRR_OFF_USER_REQ:
                    rdata_d = (i_addr == last_req_q) ? arg_q : 32'h0000_0000;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_busy = busy_q;

    // ==========================================================
    // access engines
    // ==========================================================
    temp_sensor_ctrl #(
        .HALF_CYCLES(SENSOR_HALF)
    ) u_temp (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(temp_start),
        .i_sensor_data(i_sensor_data),
        .o_sensor_clk(o_sensor_clk),
        .o_sensor_sel_n(o_sensor_sel_n),
        .o_done(temp_done),
        .o_temp(temp_val)
    ); // RULE12

    store_reader u_store (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(store_start),
        .i_user(store_user),
        .i_addr(store_addr),
        .i_mem_ack(i_mem_ack),
        .i_mem_data(i_mem_data),
        .o_mem_req(o_mem_req),
        .o_mem_user(o_mem_user),
        .o_mem_addr(o_mem_addr),
        .o_done(store_done),
        .o_byte(store_byte)
    );
endmodule
`default_nettype wire

/* verilog/store_reader.sv */
// single-byte fetch from the calibration or user store
// assumes a same-clock store port that answers a held request with an ack
`timescale 1ns/100ps
`default_nettype none
`include "qrr_consts.svh"

module store_reader (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_user,
    input wire logic [`QRR_STORE_ADDR_W-1:0] i_addr,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_data,
    output logic o_mem_req,
    output logic o_mem_user,
    output logic [`QRR_STORE_ADDR_W-1:0] o_mem_addr,
    output logic o_done,
    output logic [7:0] o_byte
);
    qrr_pkg::store_state_t state_q, state_d;
    logic req_q, req_d;
    logic user_q, user_d;
    logic [`QRR_STORE_ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] byte_q, byte_d;

    always_comb
    begin
        state_d = state_q;
        req_d = req_q;
        user_d = user_q;
        addr_d = addr_q;
        byte_d = byte_q;
        case (state_q)
            qrr_pkg::ST_IDLE:
            begin
                if (i_start)
                begin
                    req_d = 1'b1;
                    user_d = i_user;
                    addr_d = i_addr;
                    state_d = qrr_pkg::ST_WAIT;
                end
            end
            qrr_pkg::ST_WAIT:
            begin
                if (i_mem_ack)
                begin
                    req_d = 1'b0;
                    byte_d = i_mem_data;
                    state_d = qrr_pkg::ST_DONE;
                end
            end
            qrr_pkg::ST_DONE:
            begin
                state_d = qrr_pkg::ST_IDLE;
            end
            default:
            begin
                state_d = qrr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_q <= qrr_pkg::ST_IDLE;
            req_q <= 1'b0;
            user_q <= 1'b0;
            addr_q <= '0;
            byte_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            req_q <= req_d;
            user_q <= user_d;
            addr_q <= addr_d;
            byte_q <= byte_d;
        end
    end

    assign o_mem_req = req_q;
    assign o_mem_user = user_q;
    assign o_mem_addr = addr_q;
    assign o_done = (state_q == qrr_pkg::ST_DONE);
    assign o_byte = byte_q;
endmodule
`default_nettype wire

/* verilog/temp_sensor_ctrl.sv */
// serial controller for the internal temperature sensor
// assumes the sensor shifts a 16-bit frame out msb first while select is low
`timescale 1ns/100ps
`default_nettype none
`include "qrr_consts.svh"

module temp_sensor_ctrl #(
    parameter int HALF_CYCLES = `QRR_SENSOR_SCLK_NS / (2 * `QRR_CLK_NS)
)(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_sensor_data,
    output logic o_sensor_clk,
    output logic o_sensor_sel_n,
    output logic o_done,
    output logic [`QRR_TEMP_W-1:0] o_temp
);
    qrr_pkg::sen_state_t state_q, state_d;
    logic [7:0] div_q, div_d;
    logic [4:0] bits_q, bits_d;
    logic [15:0] shift_q, shift_d;
    logic sclk_q, sclk_d;
    logic sel_n_q, sel_n_d;
    logic done_q, done_d;
    logic din_meta_q, din_q;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    // sensor data is a pin: two flops before use
    always_ff @(posedge i_mclk)
    begin
        din_meta_q <= i_sensor_data;
        din_q <= din_meta_q;
    end

    always_comb
    begin
        state_d = state_q;
        div_d = div_q;
        bits_d = bits_q;
        shift_d = shift_q;
        sclk_d = sclk_q;
        sel_n_d = sel_n_q;
        done_d = 1'b0;
        case (state_q)
            qrr_pkg::SEN_IDLE:
            begin
                sclk_d = 1'b0;
                if (i_start)
                begin
                    sel_n_d = 1'b0; // RULE12
                    div_d = 8'h00;
                    bits_d = 5'h00;
                    state_d = qrr_pkg::SEN_LOW;
                end
            end
            qrr_pkg::SEN_LOW:
            begin
                div_d = div_q + 8'h01;
                if (div_q == HALF_LAST)
                begin
                    div_d = 8'h00;
                    sclk_d = 1'b1;
                    // sample a few cycles late; covers the two-flop delay
                    shift_d = {shift_q[14:0], din_q};
                    state_d = qrr_pkg::SEN_HIGH;
                end
            end
            qrr_pkg::SEN_HIGH:
            begin
                div_d = div_q + 8'h01;
                if (div_q == HALF_LAST)
                begin
                    div_d = 8'h00;
                    sclk_d = 1'b0;
                    bits_d = bits_q + 5'h01;
                    if (bits_q == `QRR_SENSOR_FRAME - 5'h01)
                    begin
                        sel_n_d = 1'b1;
                        done_d = 1'b1;
                        state_d = qrr_pkg::SEN_IDLE;
                    end
                    else
                    begin
                        state_d = qrr_pkg::SEN_LOW;
                    end
                end
            end
            default:
            begin
                state_d = qrr_pkg::SEN_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_q <= qrr_pkg::SEN_IDLE;
            div_q <= 8'h00;
            bits_q <= 5'h00;
            shift_q <= 16'h0000;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            div_q <= div_d;
            bits_q <= bits_d;
            shift_q <= shift_d;
            sclk_q <= sclk_d;
            sel_n_q <= sel_n_d;
            done_q <= done_d;
        end
    end

    assign o_sensor_clk = sclk_q;
    assign o_sensor_sel_n = sel_n_q;
    assign o_done = done_q;
    assign o_temp = shift_q[`QRR_TEMP_W-1:0];
endmodule
`default_nettype wire
